// ==== include/upio_defs.vh ====
/*
 * upio_defs.vh: offsets, reset values and pin assignments for the user
 * programmable i/o port block.
 * assumes: included by bare name from the design files.
 */
`ifndef UPIO_DEFS_VH
`define UPIO_DEFS_VH

// special function addresses
`define UPIO_SFR_P1_DATA     8'h90
`define UPIO_SFR_P1_DIR      8'h91
`define UPIO_SFR_P2_DATA     8'hD8
`define UPIO_SFR_P2_DIR      8'hD9

// external data memory addresses
`define UPIO_EXT_P3_DATA     16'h0000
`define UPIO_EXT_P3_DIR      16'h0001
`define UPIO_EXT_BANK        16'h0002
`define UPIO_EXT_P4_DATA     16'h0003
`define UPIO_EXT_P4_DIR      16'h0004

// reset values
`define UPIO_DATA_RST        8'h00
`define UPIO_DIR_RST         8'hFF
`define UPIO_BANK_RST        8'h00

// bank select register fields
`define UPIO_BANK_EN_BIT     2
`define UPIO_BANK_TOP_PIN    7

// timer pin assignment on port one
`define UPIO_T0_BIT          0
`define UPIO_T1_BIT          1
`define UPIO_T2CAP_BIT       2
`define UPIO_T2CNT_BIT       3

`endif

// ==== verilog/upio_pin_sync.v ====
/*
 * upio_pin_sync.v: three-stage pin synchroniser with agreement filter for
 * an 8-bit port.
 * assumes: pins asynchronous to mclk_i; one clock, synchronous reset.
 */
`timescale 1ns/10ps

module upio_pin_sync
(
  // clock and reset
  input  wire       mclk_i,
  input  wire       sys_rst_i,
  // pins in, filtered level out
  input  wire [7:0] pin_i,
  output reg  [7:0] level_o
);

  reg [7:0] s1_r;
  reg [7:0] s2_r;
  reg [7:0] s3_r;
  integer   i;

  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      s1_r    <= 8'hFF;
      s2_r    <= 8'hFF;
      s3_r    <= 8'hFF;
      level_o <= 8'hFF;
    end
    else
    begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // a change counts once stages two and three agree
      for (i = 0; i < 8; i = i + 1)
        if (s2_r[i] == s3_r[i])
          level_o[i] <= s2_r[i];
    end
  end

endmodule // upio_pin_sync

// ==== verilog/upio_ports.v ====
/*
 * upio_ports.v: four 8-bit user i/o ports with per-pin direction, sfr
 * access for ports one and two, external data access for ports three and
 * four, bank select on the top pin of port three, timer inputs on port one.
 * assumes: the core presents one-cycle sfr and external strobes, an rmw
 * qualifier with sfr reads, an instruction-fetch level, and reads data the
 * cycle after the strobe.
 */
`timescale 1ns/10ps
`include "upio_defs.vh"

module upio_ports
(
  // clock and reset
  input  wire        mclk_i,
  input  wire        sys_rst_i,
  // special function register bus
  input  wire [7:0]  sfr_addr_i,
  input  wire [7:0]  sfr_wdata_i,
  input  wire        sfr_wr_i,
  input  wire        sfr_rd_i,
  input  wire        sfr_rmw_i,
  output reg  [7:0]  sfr_rdata_o,
  output reg         sfr_hit_o,
  // external data memory bus
  input  wire [15:0] ext_addr_i,
  input  wire [7:0]  ext_wdata_i,
  input  wire        ext_wr_i,
  input  wire        ext_rd_i,
  output reg  [7:0]  ext_rdata_o,
  output reg         ext_hit_o,
  // bank select address
  input  wire        fetch_i,
  input  wire        prog_addr16_i,
  // port one pins
  input  wire [7:0]  port_one_i,
  output reg  [7:0]  port_one_o,
  output reg  [7:0]  port_one_oe_o,
  // port two pins
  input  wire [7:0]  port_two_i,
  output reg  [7:0]  port_two_o,
  output reg  [7:0]  port_two_oe_o,
  // port three pins
  input  wire [7:0]  port_three_i,
  output reg  [7:0]  port_three_o,
  output reg  [7:0]  port_three_oe_o,
  // port four pins
  input  wire [7:0]  port_four_i,
  output reg  [7:0]  port_four_o,
  output reg  [7:0]  port_four_oe_o,
  // timer inputs
  output reg         timer_zero_count_input_o,
  output reg         timer_one_count_input_o,
  output reg         timer_two_capture_input_o,
  output reg         timer_two_count_input_o
);

  // latches and directions
  reg  [7:0] p1_dat_r;
  reg  [7:0] p1_dir_r;
  reg  [7:0] p2_dat_r;
  reg  [7:0] p2_dir_r;
  reg  [7:0] p3_dat_r;
  reg  [7:0] p3_dir_r;
  reg  [7:0] p4_dat_r;
  reg  [7:0] p4_dir_r;
  reg  [7:0] bank_r;
  // unconfigured flags, one per port
  reg  [3:0] uncfg_r;

  wire [7:0] p1_lvl;
  wire [7:0] p2_lvl;
  wire [7:0] p3_lvl;
  wire [7:0] p4_lvl;
  wire [7:0] p1_in;
  wire [7:0] p2_in;
  wire [7:0] p3_in;
  wire [7:0] p4_in;
  wire       bank_on;
  reg  [7:0] sfr_nxt;
  reg        sfr_hit_nxt;
  reg  [7:0] ext_nxt;
  reg        ext_hit_nxt;

  // output enable: drive where direction is 0 and port configured
  function [7:0] drive_en;
    input [7:0] dir;
    input       uncfg;
    begin
      drive_en = uncfg ? 8'h00 : ~dir;
    end
  endfunction

  // internal input value: forced to 1 until configured
  function [7:0] in_val;
    input [7:0] lvl;
    input       uncfg;
    begin
      in_val = uncfg ? 8'hFF : lvl;
    end
  endfunction

  upio_pin_sync u_sync1
  (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (port_one_i),
    .level_o   (p1_lvl)
  );

  upio_pin_sync u_sync2
  (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (port_two_i),
    .level_o   (p2_lvl)
  );

  upio_pin_sync u_sync3
  (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (port_three_i),
    .level_o   (p3_lvl)
  );

  upio_pin_sync u_sync4
  (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (port_four_i),
    .level_o   (p4_lvl)
  );

  assign p1_in   = in_val(p1_lvl, uncfg_r[0]);
  assign p2_in   = in_val(p2_lvl, uncfg_r[1]);
  assign p3_in   = in_val(p3_lvl, uncfg_r[2]);
  assign p4_in   = in_val(p4_lvl, uncfg_r[3]);
  assign bank_on = bank_r[`UPIO_BANK_EN_BIT];

  // register writes
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      p1_dat_r <= `UPIO_DATA_RST;
      p1_dir_r <= `UPIO_DIR_RST;
      p2_dat_r <= `UPIO_DATA_RST;
      p2_dir_r <= `UPIO_DIR_RST;
      p3_dat_r <= `UPIO_DATA_RST;
      p3_dir_r <= `UPIO_DIR_RST;
      p4_dat_r <= `UPIO_DATA_RST;
      p4_dir_r <= `UPIO_DIR_RST;
      bank_r   <= `UPIO_BANK_RST;
      uncfg_r  <= 4'hF;
    end
    else
    begin
      if (sfr_wr_i)
      begin
        case (sfr_addr_i)
          `UPIO_SFR_P1_DATA: p1_dat_r <= sfr_wdata_i;
          `UPIO_SFR_P1_DIR:
          begin
            p1_dir_r   <= sfr_wdata_i;
            uncfg_r[0] <= 1'b0;
          end
          `UPIO_SFR_P2_DATA: p2_dat_r <= sfr_wdata_i;
          `UPIO_SFR_P2_DIR:
          begin
            p2_dir_r   <= sfr_wdata_i;
            uncfg_r[1] <= 1'b0;
          end
          default: ;
        endcase
      end
      if (ext_wr_i)
      begin
        case (ext_addr_i)
          `UPIO_EXT_P3_DATA: p3_dat_r <= ext_wdata_i;
          `UPIO_EXT_P3_DIR:
          begin
            p3_dir_r   <= ext_wdata_i;
            uncfg_r[2] <= 1'b0;
          end
          `UPIO_EXT_BANK:    bank_r   <= ext_wdata_i;
          `UPIO_EXT_P4_DATA: p4_dat_r <= ext_wdata_i;
          `UPIO_EXT_P4_DIR:
          begin
            p4_dir_r   <= ext_wdata_i;
            uncfg_r[3] <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // read decode
  always @*
  begin
    sfr_nxt     = 8'h00;
    sfr_hit_nxt = 1'b1;
    case (sfr_addr_i)
      `UPIO_SFR_P1_DATA: sfr_nxt = sfr_rmw_i ? p1_dat_r : p1_in;
      `UPIO_SFR_P1_DIR:  sfr_nxt = p1_dir_r;
      `UPIO_SFR_P2_DATA: sfr_nxt = sfr_rmw_i ? p2_dat_r : p2_in;
      `UPIO_SFR_P2_DIR:  sfr_nxt = p2_dir_r;
      default:           sfr_hit_nxt = 1'b0;
    endcase
    ext_nxt     = 8'h00;
    ext_hit_nxt = 1'b1;
    case (ext_addr_i)
      `UPIO_EXT_P3_DATA: ext_nxt = p3_in;
      `UPIO_EXT_P3_DIR:  ext_nxt = p3_dir_r;
      `UPIO_EXT_BANK:    ext_nxt = bank_r;
      `UPIO_EXT_P4_DATA: ext_nxt = p4_in;
      `UPIO_EXT_P4_DIR:  ext_nxt = p4_dir_r;
      default:           ext_hit_nxt = 1'b0;
    endcase
  end

  // registered read data and pin drive
  always @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      sfr_rdata_o               <= 8'h00;
      sfr_hit_o                 <= 1'b0;
      ext_rdata_o               <= 8'h00;
      ext_hit_o                 <= 1'b0;
      port_one_o                <= 8'h00;
      port_one_oe_o             <= 8'h00;
      port_two_o                <= 8'h00;
      port_two_oe_o             <= 8'h00;
      port_three_o              <= 8'h00;
      port_three_oe_o           <= 8'h00;
      port_four_o               <= 8'h00;
      port_four_oe_o            <= 8'h00;
      timer_zero_count_input_o  <= 1'b1;
      timer_one_count_input_o   <= 1'b1;
      timer_two_capture_input_o <= 1'b1;
      timer_two_count_input_o   <= 1'b1;
    end
    else
    begin
      if (sfr_rd_i)
      begin
        sfr_rdata_o <= sfr_nxt;
        sfr_hit_o   <= sfr_hit_nxt;
      end
      else
        sfr_hit_o <= 1'b0;
      if (ext_rd_i)
      begin
        ext_rdata_o <= ext_nxt;
        ext_hit_o   <= ext_hit_nxt;
      end
      else
        ext_hit_o <= 1'b0;
      port_one_o    <= p1_dat_r;
      port_one_oe_o <= drive_en(p1_dir_r, uncfg_r[0]);
      port_two_o    <= p2_dat_r;
      port_two_oe_o <= drive_en(p2_dir_r, uncfg_r[1]);
      port_four_o   <= p4_dat_r;
      port_four_oe_o <= drive_en(p4_dir_r, uncfg_r[3]);
      // bank mode: top pin driven with fetch address bit, latch ignored
      if (bank_on)
      begin
        port_three_o    <= {fetch_i & prog_addr16_i, p3_dat_r[6:0]};
        port_three_oe_o <= 8'h80 | drive_en(p3_dir_r, uncfg_r[2]);
      end
      else
      begin
        port_three_o    <= p3_dat_r;
        port_three_oe_o <= drive_en(p3_dir_r, uncfg_r[2]);
      end
      timer_zero_count_input_o  <= p1_in[`UPIO_T0_BIT];
      timer_one_count_input_o   <= p1_in[`UPIO_T1_BIT];
      timer_two_capture_input_o <= p1_in[`UPIO_T2CAP_BIT];
      timer_two_count_input_o   <= p1_in[`UPIO_T2CNT_BIT];
    end
  end

endmodule // upio_ports

// ==== tb/upio_ports_monitor.sv ====
/* upio_ports_monitor.sv: port-level assertions for upio_ports.
   assumes: bound to the top module; one clock, sync active-high reset. */
`timescale 1ns/10ps
module upio_mon
(
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  // buses
  input wire logic [7:0]  sfr_addr_i,
  input wire logic [7:0]  sfr_wdata_i,
  input wire logic        sfr_wr_i,
  input wire logic        sfr_rd_i,
  input wire logic [7:0]  sfr_rdata_o,
  input wire logic        sfr_hit_o,
  input wire logic [15:0] ext_addr_i,
  input wire logic [7:0]  ext_wdata_i,
  input wire logic        ext_wr_i,
  input wire logic        ext_rd_i,
  input wire logic        ext_hit_o,
  input wire logic        fetch_i,
  input wire logic        prog_addr16_i,
  // pins
  input wire logic [7:0]  port_one_oe_o,
  input wire logic [7:0]  port_three_o,
  input wire logic [7:0]  port_three_oe_o,
  input wire logic [7:0]  port_four_oe_o,
  input wire logic        timer_zero_count_input_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  reg bank_r;
  always @(posedge mclk_i)
    if (sys_rst_i)
      bank_r <= 1'b0;
    else if (ext_wr_i && ext_addr_i == 16'h0002)
      bank_r <= ext_wdata_i[2];
  chk_reset_hiz:
    assert property ($fell(sys_rst_i) |-> (port_one_oe_o | port_three_oe_o | port_four_oe_o)
      == 8'h00 && timer_zero_count_input_o) else $error("pins driven after reset");
  chk_dir_one:
    assert property (sfr_wr_i && sfr_addr_i == 8'h91 |-> ##2
      port_one_oe_o == ~$past(sfr_wdata_i, 2)) else $error("port one drive wrong");
  chk_dir_four:
    assert property (ext_wr_i && ext_addr_i == 16'h0004 |-> ##2
      port_four_oe_o == ~$past(ext_wdata_i, 2)) else $error("port four drive wrong");
  chk_sfr_hit:
    assert property (sfr_rd_i && sfr_addr_i inside {8'h90, 8'h91, 8'hD8, 8'hD9} |=> sfr_hit_o)
      else $error("sfr read not answered");
  chk_unmapped_read:
    assert property (sfr_rd_i && !(sfr_addr_i inside {8'h90, 8'h91, 8'hD8, 8'hD9})
      |=> !sfr_hit_o && sfr_rdata_o == 8'h00) else $error("unmapped read answered");
  chk_ext_hit:
    assert property (ext_rd_i && ext_addr_i == 16'h0000 |=> ext_hit_o)
      else $error("external read not answered");
  chk_hit_cause:
    assert property (sfr_hit_o |-> $past(sfr_rd_i)) else $error("hit without read");
  chk_bank_pin:
    assert property (bank_r && $past(bank_r) |-> port_three_oe_o[7] &&
      port_three_o[7] == $past(fetch_i && prog_addr16_i)) else $error("bank pin wrong");
  cover property (bank_r && fetch_i && prog_addr16_i);
  cover property (sfr_rd_i && sfr_addr_i == 8'hD8);
  cover property (ext_wr_i && ext_addr_i == 16'h0004);
endmodule // upio_mon
bind upio_ports upio_mon chk (.mclk_i, .sys_rst_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i,
  .sfr_rd_i, .sfr_rdata_o, .sfr_hit_o, .ext_addr_i, .ext_wdata_i, .ext_wr_i, .ext_rd_i,
  .ext_hit_o, .fetch_i, .prog_addr16_i, .port_one_oe_o, .port_three_o, .port_three_oe_o,
  .port_four_oe_o, .timer_zero_count_input_o);

// ==== tb/upio_pad_model.sv ====
/* upio_pad_model.sv: board side of one 8-bit user port.
   assumes: the bench gives the level outside parts put on each pin. */
`timescale 1ns/10ps
module upio_pad_model
(
  // design side
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_i,
  // board side
  input  wire logic [7:0] board_i,
  output wire logic [7:0] pin_o
);
  assign pin_o = (drv_i & oe_i) | (board_i & ~oe_i);
endmodule // upio_pad_model

// ==== tb/tb_top.sv ====
/* tb_top.sv: self-checking bench for upio_ports.
   assumes: a pad model on every port and the checker bound to the dut. */
`timescale 1ns/10ps
module tb_top;
  logic        mclk_i = 1'b0, sys_rst_i = 1'b1;
  logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, ext_wdata_i = 8'h00;
  logic        sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, sfr_rmw_i = 1'b0;
  logic        ext_wr_i = 1'b0, ext_rd_i = 1'b0, fetch_i = 1'b0, prog_addr16_i = 1'b0;
  logic [15:0] ext_addr_i = 16'h0000;
  logic [7:0]  board [0:3] = '{default: 8'h00};
  wire  [7:0]  pin [0:3], drv [0:3], oe [0:3], sfr_rdata_o, ext_rdata_o;
  wire         sfr_hit_o, ext_hit_o, tmr0, tmr1, tmr2c, tmr2n;
  logic [7:0]  expq [$];
  integer      seed = 32'hEEE1, miscompares = 0, checks_done = 0;
  genvar       g;
  always #10 mclk_i = ~mclk_i;
  for (g = 0; g < 4; g = g + 1)
  begin : pads
    upio_pad_model pad (.drv_i(drv[g]), .oe_i(oe[g]), .board_i(board[g]), .pin_o(pin[g]));
  end
  upio_ports dut (.mclk_i, .sys_rst_i, .sfr_addr_i, .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_rmw_i, .sfr_rdata_o, .sfr_hit_o, .ext_addr_i, .ext_wdata_i, .ext_wr_i, .ext_rd_i,
    .ext_rdata_o, .ext_hit_o, .fetch_i, .prog_addr16_i,
    .port_one_i(pin[0]), .port_one_o(drv[0]), .port_one_oe_o(oe[0]),
    .port_two_i(pin[1]), .port_two_o(drv[1]), .port_two_oe_o(oe[1]),
    .port_three_i(pin[2]), .port_three_o(drv[2]), .port_three_oe_o(oe[2]),
    .port_four_i(pin[3]), .port_four_o(drv[3]), .port_four_oe_o(oe[3]),
    .timer_zero_count_input_o(tmr0), .timer_one_count_input_o(tmr1),
    .timer_two_capture_input_o(tmr2c), .timer_two_count_input_o(tmr2n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  // one strobe; for reads d is the expected data
  task automatic acc(input logic x, input logic wr, input logic rmw, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    if (x)
      {ext_wr_i, ext_rd_i, ext_addr_i, ext_wdata_i} = {wr, !wr, a, d};
    else
      {sfr_wr_i, sfr_rd_i, sfr_rmw_i, sfr_addr_i, sfr_wdata_i} = {wr, !wr, rmw, a[7:0], d};
    // mapped sfr addresses all have bit 7 set
    if (!wr && (x || a[7]))
      expq.push_back(d);
    @(posedge mclk_i);
    #1;
    {ext_wr_i, ext_rd_i, sfr_wr_i, sfr_rd_i, sfr_rmw_i} = 5'h00;
  endtask
  always @(posedge mclk_i)
  begin
    #1;
    if (sfr_hit_o === 1'b1 || ext_hit_o === 1'b1)
      check(sfr_hit_o ? sfr_rdata_o : ext_rdata_o, expq.pop_front());
  end
  task automatic port_test(input int p);
    logic [7:0]  d, v, e, pv;
    logic        x;
    logic [15:0] a;
    d = $random(seed);
    v = $random(seed);
    e = $random(seed);
    x = p > 1;
    a = x ? (p == 2 ? 16'h0000 : 16'h0003) : (p == 0 ? 16'h0090 : 16'h00D8);
    board[p] = e;
    acc(x, 0, 0, a + 16'h0001, 8'hFF);
    acc(x, 0, 0, a, 8'hFF);
    acc(x, 1, 0, a + 16'h0001, d);
    acc(x, 1, 0, a, v);
    pv = (v & ~d) | (e & d);
    repeat (6) @(posedge mclk_i);
    acc(x, 0, 0, a, pv);
    acc(x, 0, 1, a, x ? pv : v);
    acc(x, 0, 0, a + 16'h0001, d);
    check(oe[p], ~d);
    check(drv[p] & ~d, v & ~d);
    if (p == 0)
      check({4'h0, tmr2n, tmr2c, tmr1, tmr0}, {4'h0, pv[3:0]});
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      port_test(p);
      $display("port %0d test done", p);
    end
    acc(1, 1, 0, 16'h0002, 8'h04);
    acc(1, 1, 0, 16'h0000, 8'hFF);
    acc(1, 0, 0, 16'h0002, 8'h04);
    for (int k = 0; k < 4; k++)
    begin
      {fetch_i, prog_addr16_i} = k[1:0];
      repeat (3) @(posedge mclk_i);
      #1;
      check({6'h00, oe[2][7], drv[2][7]}, {6'h00, 1'b1, k == 3});
    end
    $display("bank test done");
    acc(0, 0, 0, 16'h0012, 8'h00);
    check({7'h00, sfr_hit_o}, 8'h00);
    check(sfr_rdata_o, 8'h00);
    sys_rst_i = 1'b1;
    @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    check(oe[0] | oe[1] | oe[2] | oe[3], 8'h00);
    check({4'h0, tmr2n, tmr2c, tmr1, tmr0}, 8'h0F);
    repeat (2) @(posedge mclk_i);
    #1;
    check(oe[0] | oe[1] | oe[2] | oe[3], 8'h00);
    check({4'h0, tmr2n, tmr2c, tmr1, tmr0}, 8'h0F);
    check(8'(expq.size()), 8'h00);
    $display("reset test done");
    final_report;
  end
  initial
  begin
    #200000;
    miscompares++;
    final_report;
  end
endmodule // tb_top
